// ==== design/acc_clk_div.sv ====
`timescale 1ns/100ps
module acc_clk_div
  import acc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic src_sel_i,
  input wire logic xtal_tick_i,
  input wire logic [acc_pkg::ACC_PRE_W-1:0] prescale_i,
  output logic tick_o
);
  logic [3:0] cnt;
  logic [3:0] limit;
  logic src_tick;

  // Bus clock every rising edge, crystal on its ticks
  assign src_tick = src_sel_i ? 1'b1 : xtal_tick_i;

  always_comb begin
    case (prescale_i)
      3'h0: limit = 4'h0;
      3'h1: limit = 4'h1;
      3'h2: limit = 4'h3;
      3'h3: limit = 4'h7;
      default: limit = 4'hf;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (src_tick) begin
        if (cnt >= limit) begin
          cnt <= 4'h0;
          tick_o <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// ==== design/acc_conv_ctrl.sv ====
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - Interrupt enabled: request raised at end of every conversion; reset clears enable.
// - Result read or status/control write withdraws pending interrupt request.
// - Enable off: flag read-only, set per conversion, continuous after first; cleared by access.
// - Enable on: flag writable, zero means interrupt; software clears it; reset clears.
// - Continuous bit repeats conversions; else one conversion per status write; reset clears.
// - Five-bit channel field; codes 0 to 7 route external inputs 0 to 7.
// - Code 29 selects high reference, code 30 low reference.
// - All-ones channel code powers the converter down.
// - Codes 8 to 28 reserved; their results are undefined.
// - Eight-bit result register loaded on every completed conversion.
// - Prescaler: 0 by 1, 1 by 2, 2 by 4, 3 by 8, top bit by 16.
// - Clock source bit: 1 bus clock, 0 crystal; reset selects crystal.
// - Wait mode keeps converting; enabled interrupt request wakes processor.
// - Stop mode aborts conversion; conversions resume after stop exit.
// - Status/control write starts conversion lasting 16 or 17 converter clocks.
// - Continuous results overwrite previous ones whether read or not.
// - Selected shared pin forced input, port writes ignored, port reads give zero.
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int CONV_CYCLES = acc_pkg::ACC_CONV_CYCLES
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic CRYSTAL_CLOCK_I,
  input wire logic STOP_MODE_I,
  input wire logic WAIT_MODE_I,
  input wire logic CORE_DONE_I,
  input wire logic [7:0] CORE_RESULT_I,
  output logic CORE_START_O,
  output logic CORE_TICK_O,
  output logic CORE_POWER_DOWN_O,
  output logic [7:0] ANALOG_INPUTS_SEL_O,
  output logic REF_HIGH_LEVEL_SEL_O,
  output logic REF_LOW_LEVEL_SEL_O,
  output logic [7:0] PIN_FORCE_INPUT_O,
  output logic IRQ_O,
  output logic WAKE_O
);
  logic xtal_q;
  logic xtal_prev;
  logic xtal_tick;
  logic stop_q;
  logic wait_q;
  logic done_q;
  logic done_prev;
  logic done_rise;
  logic conv_tick;
  logic [4:0] channel_select;
  logic continuous_conv;
  logic conv_irq_enable;
  logic conv_complete_flag;
  logic irq_pending;
  logic first_done;
  logic [7:0] result;
  logic [7:0] clock_config_reg;
  logic [7:0] status_control_reg;
  logic [5:0] conv_cnt;
  logic start_req;
  logic powered_off;
  acc_state_t state;
  logic apb_acc;
  logic wr_sc;
  logic rd_res;
  logic wr_clk;
  logic addr_ok;
  logic conv_end;
  logic [7:0] next_pin_force;

  acc_sync #(.WIDTH(4)) u_sync (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .d_i({CRYSTAL_CLOCK_I, STOP_MODE_I, WAIT_MODE_I, CORE_DONE_I}),
    .q_o({xtal_q, stop_q, wait_q, done_q})
  );

  acc_clk_div u_div (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .src_sel_i(clock_config_reg[ACC_CLKSRC_BIT]),
    .xtal_tick_i(xtal_tick),
    .prescale_i(clock_config_reg[ACC_PRE_LSB +: ACC_PRE_W]),
    .tick_o(conv_tick)
  );

  assign xtal_tick = xtal_q & ~xtal_prev;
  assign done_rise = done_q & ~done_prev;
  assign powered_off = (channel_select == ACC_CH_OFF);
  assign apb_acc = PSEL_I & PENABLE_I & PREADY_O;
  assign addr_ok = (PADDR_I == ACC_STATUS_CONTROL_OFS) || (PADDR_I == ACC_RESULT_OFS) ||
                   (PADDR_I == ACC_CLOCK_CONFIG_OFS);
  assign wr_sc = apb_acc & PWRITE_I & (PADDR_I == ACC_STATUS_CONTROL_OFS);
  assign rd_res = apb_acc & ~PWRITE_I & (PADDR_I == ACC_RESULT_OFS);
  assign wr_clk = apb_acc & PWRITE_I & (PADDR_I == ACC_CLOCK_CONFIG_OFS);
  assign conv_end = (state == ACC_DONE);
  assign status_control_reg = {conv_complete_flag, conv_irq_enable, continuous_conv, channel_select};

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      xtal_prev <= 1'b0;
      done_prev <= 1'b0;
    end else begin
      xtal_prev <= xtal_q;
      done_prev <= done_q;
    end
  end

  // Zero-wait-state APB slave
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PREADY_O <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~addr_ok;
      PRDATA_O <= 32'h0000_0000;
      if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
        case (PADDR_I)
          ACC_STATUS_CONTROL_OFS: PRDATA_O <= {24'h000000, status_control_reg};
          ACC_RESULT_OFS: PRDATA_O <= {24'h000000, result};
          ACC_CLOCK_CONFIG_OFS: PRDATA_O <= {24'h000000, clock_config_reg};
          default: PRDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control fields
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      channel_select <= ACC_CH_RESET;
      continuous_conv <= 1'b0;
      conv_irq_enable <= 1'b0;
      clock_config_reg <= ACC_CLOCK_CONFIG_RESET;
    end else begin
      if (wr_sc) begin
        channel_select <= PWDATA_I[ACC_CH_W-1:0];
        continuous_conv <= PWDATA_I[ACC_CONT_BIT];
        conv_irq_enable <= PWDATA_I[ACC_IEN_BIT];
      end
      if (wr_clk) begin
        clock_config_reg <= {PWDATA_I[7:4], 4'h0};
      end
    end
  end

  // Start request: each status write with a channel code other than ACC_CH_OFF arms one conversion
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      start_req <= 1'b0;
    end else if (wr_sc && PWDATA_I[ACC_CH_W-1:0] != ACC_CH_OFF) begin
      start_req <= 1'b1;
    end else if (stop_q && (state == ACC_CONV || (state == ACC_DONE && continuous_conv))) begin
      start_req <= 1'b1;
    end else if (state == ACC_CONV || powered_off) begin
      start_req <= 1'b0;
    end
  end

  // Conversion sequencer
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state <= ACC_IDLE;
      conv_cnt <= 6'h00;
      CORE_START_O <= 1'b0;
    end else begin
      CORE_START_O <= 1'b0;
      if (stop_q || powered_off || wr_sc) begin
        state <= ACC_IDLE;
        conv_cnt <= 6'h00;
      end else begin
        case (state)
          ACC_IDLE: begin
            if (start_req) begin
              state <= ACC_CONV;
              conv_cnt <= 6'h00;
              CORE_START_O <= 1'b1;
            end
          end
          ACC_CONV: begin
            if (conv_tick && conv_cnt < 6'(CONV_CYCLES)) begin
              conv_cnt <= conv_cnt + 6'h01;
            end
            if (conv_cnt >= 6'(CONV_CYCLES) && (done_rise || done_q)) begin
              state <= ACC_DONE;
            end
          end
          ACC_DONE: begin
            if (continuous_conv) begin
              state <= ACC_CONV;
              conv_cnt <= 6'h00;
              CORE_START_O <= 1'b1;
            end else begin
              state <= ACC_IDLE;
            end
          end
          default: state <= ACC_IDLE;
        endcase
      end
    end
  end

  // Result latch, overwritten every conversion
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      result <= 8'h00;
    end else if (conv_end) begin
      result <= CORE_RESULT_I;
    end
  end

  // Completion flag and interrupt request; conversion end wins over a same-cycle access
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      conv_complete_flag <= 1'b0;
      irq_pending <= 1'b0;
      first_done <= 1'b0;
    end else begin
      if (wr_sc) begin
        first_done <= 1'b0;
      end else if (conv_end) begin
        first_done <= 1'b1;
      end
      if (conv_end && !conv_irq_enable && !(continuous_conv && first_done)) begin
        conv_complete_flag <= 1'b1;
      end else if (conv_end && conv_irq_enable) begin
        conv_complete_flag <= 1'b0;
      end else if (wr_sc) begin
        conv_complete_flag <= conv_irq_enable & PWDATA_I[ACC_IEN_BIT] & PWDATA_I[ACC_FLAG_BIT];
      end else if (rd_res && !conv_irq_enable) begin
        conv_complete_flag <= 1'b0;
      end
      if (conv_end && conv_irq_enable) begin
        irq_pending <= 1'b1;
      end else if (wr_sc || rd_res) begin
        irq_pending <= 1'b0;
      end
    end
  end

  // Mux selects and pin override
  always_comb begin
    next_pin_force = 8'h00;
    if (channel_select <= ACC_CH_LAST_EXT) begin
      next_pin_force[channel_select[2:0]] = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ANALOG_INPUTS_SEL_O <= 8'h00;
      PIN_FORCE_INPUT_O <= 8'h00;
      REF_HIGH_LEVEL_SEL_O <= 1'b0;
      REF_LOW_LEVEL_SEL_O <= 1'b0;
      CORE_POWER_DOWN_O <= 1'b1;
      CORE_TICK_O <= 1'b0;
      IRQ_O <= 1'b0;
      WAKE_O <= 1'b0;
    end else begin
      ANALOG_INPUTS_SEL_O <= next_pin_force;
      PIN_FORCE_INPUT_O <= next_pin_force;
      REF_HIGH_LEVEL_SEL_O <= (channel_select == ACC_CH_REF_HIGH);
      REF_LOW_LEVEL_SEL_O <= (channel_select == ACC_CH_REF_LOW);
      CORE_POWER_DOWN_O <= powered_off | stop_q;
      CORE_TICK_O <= conv_tick & (state == ACC_CONV);
      IRQ_O <= irq_pending & conv_irq_enable;
      WAKE_O <= irq_pending & conv_irq_enable & wait_q;
    end
  end
endmodule

// ==== design/acc_pkg.sv ====
package acc_pkg;
  localparam logic [11:0] ACC_STATUS_CONTROL_OFS = 12'h000;
  localparam logic [11:0] ACC_RESULT_OFS = 12'h004;
  localparam logic [11:0] ACC_CLOCK_CONFIG_OFS = 12'h008;
  localparam logic [11:0] ACC_MODE_OFS = 12'h00c;
  localparam int ACC_FLAG_BIT = 7;
  localparam int ACC_IEN_BIT = 6;
  localparam int ACC_CONT_BIT = 5;
  localparam int ACC_CLKSRC_BIT = 4;
  localparam int ACC_CH_W = 5;
  localparam int ACC_PRE_W = 3;
  localparam int ACC_PRE_LSB = 5;
  localparam logic [4:0] ACC_CH_RESET = 5'h1f;
  localparam logic [4:0] ACC_CH_REF_HIGH = 5'h1d;
  localparam logic [4:0] ACC_CH_REF_LOW = 5'h1e;
  localparam logic [4:0] ACC_CH_OFF = 5'h1f;
  localparam logic [4:0] ACC_CH_LAST_EXT = 5'h07;
  localparam logic [7:0] ACC_CLOCK_CONFIG_RESET = 8'h00;
  localparam int ACC_CONV_CYCLES = 16;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_CONV = 2'b01,
    ACC_DONE = 2'b10
  } acc_state_t;
endpackage

// ==== design/acc_sync.sv ====
`timescale 1ns/100ps
module acc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ==== testbench/acc_core_model.sv ====
`timescale 1ns/100ps
module acc_core_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic slow_i,
  input wire logic [7:0] sel_i,
  input wire logic ref_high_i,
  input wire logic ref_low_i,
  output logic done_o,
  output logic [7:0] result_o
);
  int ticks = 0;
  int hold = 0;
  logic busy = 1'b0;
  initial done_o = 1'b0;
  initial result_o = 8'h5a;
  always @(posedge clk_i) begin
    if (start_i) begin
      busy <= 1'b1;
      ticks <= 0;
      done_o <= 1'b0;
    end else if (busy && ticks >= (slow_i ? 24 : 16)) begin
      busy <= 1'b0;
      done_o <= 1'b1;
      hold <= 4;
      result_o <= ref_high_i ? 8'hff : ref_low_i ? 8'h00 : sel_i;
    end else if (busy && tick_i) begin
      ticks <= ticks + 1;
    end else if (hold > 1) begin
      hold <= hold - 1;
    end else if (hold == 1) begin
      hold <= 0;
      done_o <= 1'b0;
      result_o <= ~result_o;
    end
  end
endmodule

// ==== testbench/acc_props.sv ====
`timescale 1ns/100ps
module acc_props #(
  parameter int CONV_CYCLES = 16
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic STOP_MODE_I,
  input wire logic WAIT_MODE_I,
  input wire logic CORE_START_O,
  input wire logic CORE_TICK_O,
  input wire logic CORE_POWER_DOWN_O,
  input wire logic [7:0] ANALOG_INPUTS_SEL_O,
  input wire logic REF_HIGH_LEVEL_SEL_O,
  input wire logic REF_LOW_LEVEL_SEL_O,
  input wire logic [7:0] PIN_FORCE_INPUT_O,
  input wire logic IRQ_O,
  input wire logic WAKE_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  AST_RST_STATE: assert property ($fell(SYS_RST_I) |-> !IRQ_O && CORE_POWER_DOWN_O)
    else $error("bad state after reset");
  AST_IRQ_CLR: assert property (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 12'h000 |-> ##2 !IRQ_O)
    else $error("irq kept after status write");
  AST_WAKE: assert property ((IRQ_O && WAIT_MODE_I) [*4] |-> WAKE_O)
    else $error("no wake on irq in wait");
  AST_PD_NOSTART: assert property (CORE_POWER_DOWN_O |-> !CORE_START_O)
    else $error("start while powered down");
  AST_SEL_ONE: assert property ($onehot0({ANALOG_INPUTS_SEL_O, REF_HIGH_LEVEL_SEL_O, REF_LOW_LEVEL_SEL_O}))
    else $error("input select not one-hot");
  AST_PIN_FORCE: assert property (PIN_FORCE_INPUT_O == ANALOG_INPUTS_SEL_O)
    else $error("forced pin differs from channel");
  AST_START_GAP: assert property (CORE_START_O |=> !CORE_START_O [*8])
    else $error("start pulses too close");
  AST_STOP_IDLE: assert property (STOP_MODE_I [*5] |-> CORE_POWER_DOWN_O && !CORE_TICK_O)
    else $error("core active in stop");
  CV_WAKE: cover property (IRQ_O && WAIT_MODE_I);
  CV_START: cover property ($rose(CORE_START_O));
  CV_STOP: cover property (STOP_MODE_I ##5 CORE_POWER_DOWN_O);
endmodule
bind acc_conv_ctrl acc_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .STOP_MODE_I(STOP_MODE_I),
  .WAIT_MODE_I(WAIT_MODE_I), .CORE_START_O(CORE_START_O), .CORE_TICK_O(CORE_TICK_O),
  .CORE_POWER_DOWN_O(CORE_POWER_DOWN_O), .ANALOG_INPUTS_SEL_O(ANALOG_INPUTS_SEL_O),
  .REF_HIGH_LEVEL_SEL_O(REF_HIGH_LEVEL_SEL_O), .REF_LOW_LEVEL_SEL_O(REF_LOW_LEVEL_SEL_O),
  .PIN_FORCE_INPUT_O(PIN_FORCE_INPUT_O), .IRQ_O(IRQ_O), .WAKE_O(WAKE_O));

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import acc_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, xtal = 0, stop = 0, wt = 0, slow = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic pready, pslverr, start, tick, pd, rh, rl, irq, wake, done;
  logic [7:0] res, sel, pin;
  logic [7:0] cfg [7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hf0, 8'h00};
  int dv [7] = '{1, 2, 4, 8, 16, 16, 4};
  logic [4:0] chs [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 29, 30, 8};
  int fails = 0, n_checks = 0, starts = 0, cyc = 0, n, k;
  always #5 clk = ~clk;
  acc_conv_ctrl uut (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .CRYSTAL_CLOCK_I(xtal), .STOP_MODE_I(stop), .WAIT_MODE_I(wt), .CORE_DONE_I(done), .CORE_RESULT_I(res),
    .CORE_START_O(start), .CORE_TICK_O(tick), .CORE_POWER_DOWN_O(pd), .ANALOG_INPUTS_SEL_O(sel),
    .REF_HIGH_LEVEL_SEL_O(rh), .REF_LOW_LEVEL_SEL_O(rl), .PIN_FORCE_INPUT_O(pin), .IRQ_O(irq), .WAKE_O(wake));
  acc_core_model model (.clk_i(clk), .start_i(start), .tick_i(tick), .slow_i(slow), .sel_i(sel),
    .ref_high_i(rh), .ref_low_i(rl), .done_o(done), .result_o(res));
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (start === 1'b1) starts <= starts + 1;
    if (cyc % 2 == 1) xtal <= ~xtal;
    if (cyc == 30000) begin
      fails = fails + 1;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(rdv, exp);
  endtask
  task automatic poll;
    do apb(0, ACC_STATUS_CONTROL_OFS, 0); while (rdv[ACC_FLAG_BIT] !== 1'b1);
  endtask
  task automatic wait_irq;
    k = 0;
    while (irq !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(ACC_STATUS_CONTROL_OFS, 32'h1f);
    rd(ACC_CLOCK_CONFIG_OFS, 32'h00);
    rd(12'h010, 32'h00);
    chk(err, 1'b1);
    $display("Reset values done");
    for (int i = 0; i < 7; i++) begin
      wr_cfg: apb(1, ACC_CLOCK_CONFIG_OFS, {24'h0, cfg[i]});
      apb(1, ACC_STATUS_CONTROL_OFS, 32'h00);
      k = 0;
      while (tick !== 1'b1 && k < 100) begin
        @(posedge clk);
        k++;
      end
      n = 0;
      k = 0;
      while (k < 4 && n < 300) begin
        @(posedge clk);
        n++;
        if (tick === 1'b1) k++;
      end
      chk(n, 4 * dv[i]);
      poll();
    end
    apb(1, ACC_CLOCK_CONFIG_OFS, 32'h1f);
    rd(ACC_CLOCK_CONFIG_OFS, 32'h10);
    $display("Clock divider done");
    for (int i = 0; i < 11; i++) begin
      k = starts;
      apb(1, ACC_STATUS_CONTROL_OFS, {27'h0, chs[i]});
      poll();
      chk(pin, i < 8 ? 32'h1 << i : 32'h0);
      if (i < 10) rd(ACC_RESULT_OFS, i < 8 ? 32'h1 << i : i == 8 ? 32'hff : 32'h00);
      else apb(0, ACC_RESULT_OFS, 0);
      rd(ACC_STATUS_CONTROL_OFS, {27'h0, chs[i]});
      chk(starts - k, 1);
    end
    $display("Channels done");
    wt <= 1;
    apb(1, ACC_STATUS_CONTROL_OFS, 32'h42);
    wait_irq();
    chk(irq, 1'b1);
    repeat (4) @(posedge clk);
    chk(wake, 1'b1);
    rd(ACC_STATUS_CONTROL_OFS, 32'h42);
    rd(ACC_RESULT_OFS, 32'h04);
    @(posedge clk);
    chk(irq, 1'b0);
    apb(1, ACC_STATUS_CONTROL_OFS, 32'hc2);
    rd(ACC_STATUS_CONTROL_OFS, 32'hc2);
    wait_irq();
    rd(ACC_STATUS_CONTROL_OFS, 32'h42);
    apb(1, ACC_STATUS_CONTROL_OFS, 32'h02);
    @(posedge clk);
    chk(irq, 1'b0);
    wt <= 0;
    poll();
    $display("Interrupt done");
    slow <= 1;
    k = starts;
    apb(1, ACC_STATUS_CONTROL_OFS, 32'h23);
    poll();
    rd(ACC_RESULT_OFS, 32'h08);
    repeat (150) @(posedge clk);
    rd(ACC_STATUS_CONTROL_OFS, 32'h23);
    chk(starts - k >= 4, 1'b1);
    stop <= 1;
    repeat (8) @(posedge clk);
    k = starts;
    repeat (100) @(posedge clk);
    chk(starts - k, 0);
    chk(pd, 1'b1);
    stop <= 0;
    repeat (100) @(posedge clk);
    chk(starts - k > 0, 1'b1);
    rd(ACC_RESULT_OFS, 32'h08);
    apb(1, ACC_STATUS_CONTROL_OFS, 32'h1f);
    wt <= 1;
    repeat (8) @(posedge clk);
    k = starts;
    chk(pd, 1'b1);
    repeat (60) @(posedge clk);
    chk(starts - k, 0);
    chk(wake, 1'b0);
    $display("Continuous and stop done");
    test_done();
  end
endmodule
